// file: core/pcg_consts.svh
// register offsets, field positions, reset values and timing counts
`ifndef PCG_CONSTS_SVH
`define PCG_CONSTS_SVH

`define PCG_ADDR_W 8
`define PCG_ADDR_CTL 8'h1C
`define PCG_ADDR_BWC 8'h1D
`define PCG_ADDR_MRG 8'h1E

`define PCG_RST_CTL 8'h2F
`define PCG_RST_BWC 8'h00
`define PCG_RST_MRG 8'h66

`define PCG_CTL_IRQ_EN 7
`define PCG_CTL_FLAG 6
`define PCG_CTL_PWR 5
`define PCG_CTL_SRC 4
`define PCG_CTL_ONES 4'hF

`define PCG_BWC_AUTO 7
`define PCG_BWC_LOCK 6
`define PCG_BWC_TRK 5

`define PCG_MRG_N_HI 7
`define PCG_MRG_N_LO 4
`define PCG_MRG_L_HI 3
`define PCG_MRG_L_LO 0

`define PCG_NOM_HZ 32'd4915200
`define PCG_HOLD_EDGES 2'h3

`define PCG_DET_WINDOW 8'h10
`define PCG_DET_TRK_TOL 8'h02
`define PCG_DET_UNT_TOL 8'h03
`define PCG_DET_LOCK_TOL 8'h01
`define PCG_DET_UNL_TOL 8'h02

`endif

// file: core/pcg_lock_det.sv
// frequency lock detector: counts feedback edges per reference window
`timescale 1ns/1ns
`default_nettype none
`include "pcg_consts.svh"
module pcg_lock_det
    import pcg_pkg::*;
#(
    parameter logic [7:0] WINDOW = `PCG_DET_WINDOW,
    parameter logic [7:0] TRK_TOL = `PCG_DET_TRK_TOL,
    parameter logic [7:0] UNT_TOL = `PCG_DET_UNT_TOL,
    parameter logic [7:0] LOCK_TOL = `PCG_DET_LOCK_TOL,
    parameter logic [7:0] UNL_TOL = `PCG_DET_UNL_TOL
)
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic ref_rise,
    input wire logic fb_rise,
    output logic tracking,
    output logic locked
);
    logic [7:0] ref_cnt_ff;
    logic [7:0] fb_cnt_ff;
    logic tracking_ff;
    logic locked_ff;
    logic win_end;
    logic [7:0] fb_total;
    logic [7:0] err;

    assign win_end = ref_rise && (ref_cnt_ff == WINDOW - 8'h01);
    assign fb_total = fb_cnt_ff + {7'h00, fb_rise};
    assign err = (fb_total > WINDOW) ? fb_total - WINDOW : WINDOW - fb_total;

    always_ff @(posedge core_clk)
    begin
        if (!nrst || !run || win_end)
        begin
            ref_cnt_ff <= 8'h00;
            fb_cnt_ff <= 8'h00;
        end
        else
        begin
            if (ref_rise)
                ref_cnt_ff <= ref_cnt_ff + 8'h01;
            if (fb_rise && fb_cnt_ff != 8'hFF)
                fb_cnt_ff <= fb_cnt_ff + 8'h01;
        end
    end

    // separate enter and leave tolerances give hysteresis against chatter
    always_ff @(posedge core_clk)
    begin
        if (!nrst || !run)
        begin
            tracking_ff <= 1'b0;
            locked_ff <= 1'b0;
        end
        else if (win_end)
        begin
            if (err <= TRK_TOL)
                tracking_ff <= 1'b1;
            else if (err > UNT_TOL)
                tracking_ff <= 1'b0;
            if (err <= LOCK_TOL)
                locked_ff <= 1'b1;
            else if (err > UNL_TOL)
                locked_ff <= 1'b0;
        end
    end

    assign tracking = tracking_ff;
    assign locked = locked_ff;
endmodule
`default_nettype wire

// file: core/pcg_pkg.sv
// types shared by the clock generator modules
package pcg_pkg;

    typedef struct packed {
        logic irq_en;
        logic power_on;
        logic src_sel;
    } pcg_ctl_s;

    typedef struct packed {
        logic auto_bw;
        logic trk_manual;
    } pcg_bwc_s;

    typedef struct packed {
        logic [3:0] mult;
        logic [3:0] range;
    } pcg_mrg_s;

    typedef enum logic [2:0] {
        SEL_RUN = 3'b001,
        SEL_HOLD_OLD = 3'b010,
        SEL_HOLD_NEW = 3'b100
    } pcg_sel_e;

endpackage

// file: core/pcg_top.sv
// clock generator control: registers, dividers, selector, lock logic
// Operation
// RULE1: base clock is crystal or vco clock halved, chosen by software
// RULE2: crystal clock buffered to loop reference, same frequency as final one
// RULE3: vco clock divided modulo N to give the feedback clock
// RULE4: vco center frequency is L times nominal, range half to double
// RULE5: lock detector compares feedback and reference frequencies
// RULE6: acquisition mode reads as tracking bit zero
// RULE7: tracking whenever not in acquisition or tracking bit is one
// RULE8: in automatic mode the detector switches filter mode itself
// RULE9: automatic mode: tracking bit read-only, set/cleared by tolerances
// RULE10: automatic mode: settled flag read-only with lock/unlock tolerances
// RULE11: automatic mode with enable: interrupt on each lock change
// RULE12: software uses vco source only once settled flag is one
// RULE13: manual mode: tracking bit is a writable filter mode control
// RULE14: manual mode: software clears tracking bit before loop power on
// RULE15: manual mode: software waits acquisition time before tracking
// RULE16: manual mode: software waits lock time before choosing vco
// RULE17: manual mode: settled flag off and no interrupts
// RULE18: crystal oscillator runs only while oscillator enable is high
// RULE19: multiplier register: N in upper nibble, L in lower nibble
// RULE20: N of zero divides by one; L of zero disables loop
// RULE21: refuse vco while off, off while vco, and both changes at once
// RULE22: source change holds base clock up to three edges each clock
// RULE23: detector counts feedback edges per reference window vs tolerances
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "pcg_consts.svh"
module pcg_top
    import pcg_pkg::*;
#(
    parameter logic [7:0] DET_WINDOW = `PCG_DET_WINDOW,
    parameter logic [7:0] TRK_TOL = `PCG_DET_TRK_TOL,
    parameter logic [7:0] UNT_TOL = `PCG_DET_UNT_TOL,
    parameter logic [7:0] LOCK_TOL = `PCG_DET_LOCK_TOL,
    parameter logic [7:0] UNL_TOL = `PCG_DET_UNL_TOL
)
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [`PCG_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic oscillator_enable_in,
    input wire logic oscillator_input_pin,
    output logic oscillator_output_pin,
    input wire logic vco_clock,
    output logic crystal_clock,
    output logic loop_reference_clock,
    output logic final_reference_clock,
    output logic vco_feedback_clock,
    output logic base_clock_out,
    output logic loop_enable,
    output logic filter_tracking,
    output logic [3:0] vco_range_select,
    output logic [31:0] vco_center_hz,
    output logic clockgen_irq
);
    // pin synchronisers: index 0 oscillator pin, index 1 vco clock
    logic [1:0] pin_raw;
    logic [1:0] sync1_ff;
    logic [1:0] sync2_ff;
    logic [1:0] sync3_ff;
    logic [1:0] clean_ff;
    logic [1:0] rise;

    assign pin_raw = {vco_clock, oscillator_input_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_sync
            always_ff @(posedge core_clk)
            begin
                if (!nrst)
                begin
                    sync1_ff[gi] <= 1'b0;
                    sync2_ff[gi] <= 1'b0;
                    sync3_ff[gi] <= 1'b0;
                    clean_ff[gi] <= 1'b0;
                end
                else
                begin
                    sync1_ff[gi] <= pin_raw[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                    sync3_ff[gi] <= sync2_ff[gi];
                    if (sync2_ff[gi] == sync3_ff[gi])
                        clean_ff[gi] <= sync2_ff[gi];
                end
            end
            assign rise[gi] = (sync2_ff[gi] == sync3_ff[gi])
                && sync2_ff[gi] && !clean_ff[gi];
        end
    endgenerate

    // register state
    pcg_ctl_s ctl_ff;
    pcg_bwc_s bwc_ff;
    pcg_mrg_s mrg_ff;
    logic flag_ff;
    logic [7:0] rdata_ff;

    logic loop_on;
    logic src_vco;
    logic xtal_rise;
    logic vco_rise;
    logic trk_det;
    logic lock_det;
    logic trk_bit;
    logic lock_bit;
    logic lock_bit_ff;
    logic lock_edge;
    logic fb_pulse_ff;

    function automatic logic hit(input logic [`PCG_ADDR_W-1:0] a,
                                 input logic [`PCG_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    // crystal stops when the system disables the oscillator
    assign xtal_rise = rise[0] && oscillator_enable_in; // see RULE18
    // loop needs power, a nonzero range and a running crystal
    assign loop_on = ctl_ff.power_on && (mrg_ff.range != 4'h0)
        && oscillator_enable_in; // see RULE20
    assign vco_rise = rise[1] && loop_on;
    // zero range forces the crystal as source
    assign src_vco = ctl_ff.src_sel && (mrg_ff.range != 4'h0); // see RULE20

    // control register write, with refusal of illegal combinations
    logic wr_ctl;
    logic want_pwr;
    logic want_src;
    logic chg_pwr;
    logic chg_src;

    assign wr_ctl = reg_wr && hit(reg_addr, `PCG_ADDR_CTL);
    assign want_pwr = reg_wdata[`PCG_CTL_PWR];
    assign want_src = reg_wdata[`PCG_CTL_SRC];
    assign chg_pwr = want_pwr != ctl_ff.power_on;
    assign chg_src = want_src != ctl_ff.src_sel;

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            ctl_ff.irq_en <= 1'(`PCG_RST_CTL >> `PCG_CTL_IRQ_EN);
            ctl_ff.power_on <= 1'b1;
            ctl_ff.src_sel <= 1'b0;
        end
        else if (wr_ctl)
        begin
            ctl_ff.irq_en <= reg_wdata[`PCG_CTL_IRQ_EN];
            // both at once is rejected, each alone is checked
            if (!(chg_pwr && chg_src)) // see RULE21
            begin
                if (chg_pwr && !(!want_pwr && ctl_ff.src_sel)) // see RULE21
                    ctl_ff.power_on <= want_pwr;
                if (chg_src && !(want_src && !ctl_ff.power_on)
                    && !(want_src && mrg_ff.range == 4'h0)) // see RULE21
                    ctl_ff.src_sel <= want_src;
            end
        end
    end

    // bandwidth register
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            bwc_ff.auto_bw <= 1'b0;
            bwc_ff.trk_manual <= 1'b0;
        end
        else if (reg_wr && hit(reg_addr, `PCG_ADDR_BWC))
        begin
            bwc_ff.auto_bw <= reg_wdata[`PCG_BWC_AUTO];
            // the mode bit is only a control while in manual mode
            if (!bwc_ff.auto_bw) // see RULE13
                bwc_ff.trk_manual <= reg_wdata[`PCG_BWC_TRK];
        end
    end

    // multiplier and range register
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            mrg_ff <= `PCG_RST_MRG;
        else if (reg_wr && hit(reg_addr, `PCG_ADDR_MRG))
            mrg_ff <= reg_wdata; // see RULE19
    end

    // lock detector runs only in automatic mode with the loop on
    pcg_lock_det #(
        .WINDOW(DET_WINDOW),
        .TRK_TOL(TRK_TOL),
        .UNT_TOL(UNT_TOL),
        .LOCK_TOL(LOCK_TOL),
        .UNL_TOL(UNL_TOL)
    ) u_det (
        .core_clk(core_clk),
        .nrst(nrst),
        .run(loop_on && bwc_ff.auto_bw), // see RULE8
        .ref_rise(xtal_rise), // see RULE5
        .fb_rise(fb_pulse_ff),
        .tracking(trk_det), // see RULE9
        .locked(lock_det) // see RULE10 RULE23
    );

    // in manual mode the settled flag is held off
    assign lock_bit = bwc_ff.auto_bw && lock_det; // see RULE17
    assign trk_bit = bwc_ff.auto_bw ? trk_det : bwc_ff.trk_manual; // see RULE6

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            lock_bit_ff <= 1'b0;
        else
            lock_bit_ff <= lock_bit;
    end

    assign lock_edge = bwc_ff.auto_bw && (lock_bit != lock_bit_ff);

    // change flag clears on a control read; a new change wins over it
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            flag_ff <= 1'b0;
        else if (lock_edge) // see RULE11
            flag_ff <= 1'b1;
        else if (reg_rd && hit(reg_addr, `PCG_ADDR_CTL))
            flag_ff <= 1'b0;
    end

    assign clockgen_irq = flag_ff && ctl_ff.irq_en
        && bwc_ff.auto_bw; // see RULE11 RULE17

    // register read, data valid the cycle after the strobe only
    always_ff @(posedge core_clk)
    begin
        if (!nrst || !reg_rd)
            rdata_ff <= 8'h00;
        else if (hit(reg_addr, `PCG_ADDR_CTL))
            rdata_ff <= {ctl_ff.irq_en, flag_ff, ctl_ff.power_on,
                ctl_ff.src_sel, `PCG_CTL_ONES};
        else if (hit(reg_addr, `PCG_ADDR_BWC))
            rdata_ff <= {bwc_ff.auto_bw, lock_bit, trk_bit, 5'h00};
        else if (hit(reg_addr, `PCG_ADDR_MRG))
            rdata_ff <= mrg_ff;
        else
            rdata_ff <= 8'h00;
    end

    assign reg_rdata = rdata_ff;

    // feedback divider: one pulse every N vco edges
    logic [3:0] n_eff;
    logic [3:0] fb_cnt_ff;

    assign n_eff = (mrg_ff.mult == 4'h0) ? 4'h1 : mrg_ff.mult; // see RULE20

    always_ff @(posedge core_clk)
    begin
        if (!nrst || !loop_on)
        begin
            fb_cnt_ff <= 4'h0;
            fb_pulse_ff <= 1'b0;
        end
        else if (vco_rise && fb_cnt_ff >= n_eff - 4'h1) // see RULE3
        begin
            fb_cnt_ff <= 4'h0;
            fb_pulse_ff <= 1'b1;
        end
        else
        begin
            if (vco_rise)
                fb_cnt_ff <= fb_cnt_ff + 4'h1;
            fb_pulse_ff <= 1'b0;
        end
    end

    // clock outputs and loop controls
    logic xtal_ff;
    logic osc_out_ff;
    logic trk_out_ff;
    logic [31:0] center_ff;

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            xtal_ff <= 1'b0;
            osc_out_ff <= 1'b0;
        end
        else
        begin
            xtal_ff <= clean_ff[0] && oscillator_enable_in; // see RULE18
            osc_out_ff <= oscillator_enable_in && !clean_ff[0];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            trk_out_ff <= 1'b0;
            center_ff <= 32'h0;
        end
        else
        begin
            // tracking when the loop is on and the mode bit is one, acquisition otherwise
            trk_out_ff <= loop_on && trk_bit; // see RULE7
            center_ff <= 32'({28'h0, mrg_ff.range} * `PCG_NOM_HZ); // see RULE4
        end
    end

    assign crystal_clock = xtal_ff;
    // reference path is a buffer: same frequency end to end
    assign loop_reference_clock = xtal_ff; // see RULE2
    assign final_reference_clock = xtal_ff; // see RULE2
    assign vco_feedback_clock = fb_pulse_ff;
    assign oscillator_output_pin = osc_out_ff;
    assign filter_tracking = trk_out_ff;
    assign loop_enable = loop_on;
    assign vco_range_select = mrg_ff.range;
    assign vco_center_hz = center_ff;

    // base clock selector with glitch-free hand-over
    pcg_sel_e sel_st_ff;
    logic cur_vco_ff;
    logic [1:0] hold_cnt_ff;
    logic base_ff;
    logic old_rise;
    logic new_rise;
    logic cur_rise;

    assign old_rise = cur_vco_ff ? vco_rise : xtal_rise;
    assign new_rise = src_vco ? vco_rise : xtal_rise;
    assign cur_rise = cur_vco_ff ? vco_rise : xtal_rise;

    // a stopped loop would hang the old-source wait, so it ends when the loop is off
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            sel_st_ff <= SEL_RUN;
            cur_vco_ff <= 1'b0;
            hold_cnt_ff <= 2'h0;
        end
        else
        begin
            unique case (sel_st_ff)
                SEL_RUN:
                    if (src_vco != cur_vco_ff) // see RULE22
                    begin
                        sel_st_ff <= SEL_HOLD_OLD;
                        hold_cnt_ff <= 2'h0;
                    end
                SEL_HOLD_OLD:
                    if (old_rise || !loop_on)
                    begin
                        if (hold_cnt_ff == `PCG_HOLD_EDGES - 2'h1 || !loop_on)
                        begin
                            sel_st_ff <= SEL_HOLD_NEW;
                            hold_cnt_ff <= 2'h0;
                        end
                        else
                            hold_cnt_ff <= hold_cnt_ff + 2'h1;
                    end
                SEL_HOLD_NEW:
                    if (new_rise)
                    begin
                        if (hold_cnt_ff == `PCG_HOLD_EDGES - 2'h1)
                        begin
                            sel_st_ff <= SEL_RUN;
                            cur_vco_ff <= src_vco; // see RULE1
                        end
                        else
                            hold_cnt_ff <= hold_cnt_ff + 2'h1;
                    end
                default:
                    sel_st_ff <= SEL_RUN;
            endcase
        end
    end

    // halving gives a 50% duty base clock whatever the source duty
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            base_ff <= 1'b0;
        else if (sel_st_ff == SEL_RUN && cur_rise)
            base_ff <= !base_ff; // see RULE1 RULE22
    end

    assign base_clock_out = base_ff;
endmodule
`default_nettype wire

// file: tb/pcg_clk_src_model.sv
// behavioural crystal and vco sources feeding the clock generator
`timescale 1ns/1ns
`default_nettype none
module pcg_clk_src_model
(
    input var int xtal_half,
    input var int vco_half,
    input wire logic vco_run,
    output logic osc_pin,
    output logic vco_clk
);
    initial osc_pin = 1'h0;
    initial vco_clk = 1'h0;
    // external clock fed into the amplifier input, output pin left open
    always #(xtal_half) osc_pin = ~osc_pin;
    // vco stands still low while the loop is off
    always
    begin
        if (vco_run === 1'h1)
            #(vco_half) vco_clk = ~vco_clk;
        else
        begin
            vco_clk = 1'h0;
            @(vco_run);
        end
    end
endmodule
`default_nettype wire

// file: tb/pcg_top_assertions.sv
// port-level assertions for the clock generator control block
`timescale 1ns/1ns
`default_nettype none
`include "pcg_consts.svh"
module pcg_top_assertions
    import pcg_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [`PCG_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic oscillator_enable_in,
    input wire logic crystal_clock,
    input wire logic loop_reference_clock,
    input wire logic final_reference_clock,
    input wire logic vco_feedback_clock,
    input wire logic base_clock_out,
    input wire logic loop_enable,
    input wire logic [3:0] vco_range_select,
    input wire logic [31:0] vco_center_hz,
    input wire logic clockgen_irq
);
    logic ctl_wr;
    logic bwc_wr;
    logic mrg_wr;
    logic bad_rd;
    logic [3:0] wd_lo;
    assign ctl_wr = reg_wr && reg_addr == `PCG_ADDR_CTL;
    assign bwc_wr = reg_wr && reg_addr == `PCG_ADDR_BWC;
    assign mrg_wr = reg_wr && reg_addr == `PCG_ADDR_MRG;
    assign bad_rd = reg_rd
        && (reg_addr < `PCG_ADDR_CTL || reg_addr > `PCG_ADDR_MRG);
    assign wd_lo = reg_wdata[3:0];
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    rdata_idle_a: assert property (!$past(reg_rd)
        |-> reg_rdata == 8'h00)
        else $error("read data not zero outside the read slot");
    ctl_ones_a: assert property (reg_rd
        && reg_addr == `PCG_ADDR_CTL |=> reg_rdata[3:0] == 4'hF)
        else $error("control low nibble not all ones");
    unmapped_a: assert property (bad_rd |=> reg_rdata == 8'h00)
        else $error("unmapped read returned data");
    range_wr_a: assert property (mrg_wr
        |=> vco_range_select == $past(wd_lo))
        else $error("range field not taken from low nibble");
    center_hz_a: assert property ($past(nrst) && $stable(vco_range_select)
        |-> vco_center_hz == `PCG_NOM_HZ * 32'(vco_range_select))
        else $error("center frequency not range times nominal");
    ref_same_a: assert property (loop_reference_clock == crystal_clock
        && final_reference_clock == crystal_clock)
        else $error("reference clocks differ from crystal");
    osc_off_a: assert property (!oscillator_enable_in [*3]
        |-> !crystal_clock && !loop_enable)
        else $error("crystal or loop active while osc off");
    range_zero_a: assert property (vco_range_select == 4'h0 |-> !loop_enable)
        else $error("loop enabled with zero range");
    irq_mask_a: assert property (ctl_wr
        && !reg_wdata[`PCG_CTL_IRQ_EN] |=> !clockgen_irq)
        else $error("interrupt raised while disabled");
    manual_irq_a: assert property (bwc_wr
        && !reg_wdata[`PCG_BWC_AUTO] |=> !clockgen_irq)
        else $error("interrupt raised in manual mode");
    fb_pulse_a: assert property (vco_feedback_clock |=> !vco_feedback_clock)
        else $error("feedback pulse longer than one cycle");
    // a pin clock at most a fifth of the core rate cannot toggle faster
    base_slow_a: assert property ($changed(base_clock_out)
        |=> $stable(base_clock_out) [*4])
        else $error("base clock toggled too fast");
    cover property ($rose(clockgen_irq));
    cover property (ctl_wr && reg_wdata[`PCG_CTL_SRC]);
    cover property (bwc_wr && reg_wdata[`PCG_BWC_TRK]
        && !reg_wdata[`PCG_BWC_AUTO]);
endmodule
bind pcg_top pcg_top_assertions u_pcg_top_assertions (
    .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .oscillator_enable_in(oscillator_enable_in),
    .crystal_clock(crystal_clock), .loop_reference_clock(loop_reference_clock),
    .final_reference_clock(final_reference_clock),
    .vco_feedback_clock(vco_feedback_clock), .base_clock_out(base_clock_out),
    .loop_enable(loop_enable), .vco_range_select(vco_range_select),
    .vco_center_hz(vco_center_hz), .clockgen_irq(clockgen_irq)
);
`default_nettype wire

// file: tb/pcg_top_test.sv
// self-checking bench for the clock generator control block
`timescale 1ns/1ns
`default_nettype none
`include "pcg_consts.svh"
module pcg_top_test
    import pcg_pkg::*;
;
    localparam int LIMIT = 30000;
    localparam int T_WAIT = 100;
    localparam logic [7:0] CTL = `PCG_ADDR_CTL;
    localparam logic [7:0] BWC = `PCG_ADDR_BWC;
    localparam logic [7:0] MRG = `PCG_ADDR_MRG;
    logic core_clk = 1'h0;
    logic nrst = 1'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic osc_en = 1'h1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic osc_pin, vco_clk, xclk, fb, base, loop_en, trk, irq, opin;
    logic [3:0] vrs;
    logic [31:0] ctr_hz;
    int xh = 400;
    int vh = 200;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    int nfb, nbase, nx;
    always #20 core_clk = ~core_clk;
    // short window keeps lock decisions within a few hundred cycles
    pcg_top #(.DET_WINDOW(8'h04)) u_pcg_top (
        .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .oscillator_enable_in(osc_en),
        .oscillator_input_pin(osc_pin), .oscillator_output_pin(opin),
        .vco_clock(vco_clk), .crystal_clock(xclk),
        .loop_reference_clock(), .final_reference_clock(),
        .vco_feedback_clock(fb), .base_clock_out(base),
        .loop_enable(loop_en), .filter_tracking(trk),
        .vco_range_select(vrs), .vco_center_hz(ctr_hz), .clockgen_irq(irq));
    pcg_clk_src_model u_pcg_clk_src_model (.xtal_half(xh), .vco_half(vh),
        .vco_run(loop_en), .osc_pin(osc_pin), .vco_clk(vco_clk));
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic near(input string nm, input int e, g);
        chk(nm, 32'h1, 32'(g >= e - 1 && g <= e + 1));
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 d = reg_rdata;
    endtask
    task automatic rchk(input logic [7:0] a, e, input string nm);
        logic [7:0] d;
        rd(a, d);
        chk(nm, 32'(e), 32'(d));
    endtask
    task automatic measure(input int n);
        logic pb;
        logic px;
        nfb = 0;
        nbase = 0;
        nx = 0;
        @(negedge core_clk);
        pb = base;
        px = xclk;
        repeat (n)
        begin
            @(negedge core_clk);
            nfb += int'(fb === 1'h1);
            nbase += int'(base !== pb);
            nx += int'(xclk === 1'h1 && px !== 1'h1);
            pb = base;
            px = xclk;
        end
    endtask
    task automatic wait_lock(input logic e);
        logic [7:0] d;
        d = 8'h00;
        for (int i = 0; i < 60; i++)
        begin
            rd(BWC, d);
            if (d[`PCG_BWC_LOCK] === e)
                break;
            repeat (20) @(posedge core_clk);
        end
        chk("lock_bit", 32'(e), 32'(d[`PCG_BWC_LOCK]));
    endtask
    task automatic t_regs();
        rchk(CTL, `PCG_RST_CTL, "ctl_reset");
        rchk(BWC, `PCG_RST_BWC, "bwc_reset");
        rchk(MRG, `PCG_RST_MRG, "mrg_reset");
        wr(8'h1F, 8'hFF);
        rchk(8'h1F, 8'h00, "unmapped");
        wr(MRG, 8'h20);
        repeat (2) @(negedge core_clk);
        chk("loop_en_l0", 32'h0, 32'(loop_en));
        wr(CTL, 8'h30);
        rchk(CTL, 8'h2F, "src_l0");
        wr(MRG, 8'h21);
        repeat (2) @(negedge core_clk);
        chk("range", 32'h1, 32'(vrs));
        chk("center", `PCG_NOM_HZ, ctr_hz);
        rchk(MRG, 8'h21, "mrg_rw");
    endtask
    task automatic t_auto();
        wr(BWC, 8'h80);
        wr(CTL, 8'hA0);
        wait_lock(1'h1);
        chk("irq_lock", 32'h1, 32'(irq));
        chk("trk_auto", 32'h1, 32'(trk));
        wr(BWC, 8'h80);
        rchk(BWC, 8'hE0, "bwc_auto");
        rchk(CTL, 8'hEF, "flag_set");
        chk("irq_clr", 32'h0, 32'(irq));
        measure(400);
        near("fb_div", 20, nfb);
        near("base_x", 20, nbase);
    endtask
    task automatic t_switch();
        wr(CTL, 8'hB0);
        rchk(CTL, 8'hBF, "src_vco");
        measure(40);
        chk("hold", 32'h0, 32'(nbase));
        repeat (T_WAIT) @(posedge core_clk);
        measure(400);
        near("base_v", 40, nbase);
        wr(CTL, 8'h90);
        rchk(CTL, 8'hBF, "off_vco");
        wr(CTL, 8'h80);
        rchk(CTL, 8'hBF, "both_chg");
        wr(CTL, 8'hA0);
        rchk(CTL, 8'hAF, "src_x");
    endtask
    task automatic t_unlock();
        vh = 4000;
        wait_lock(1'h0);
        chk("irq_unl", 32'h1, 32'(irq));
        repeat (400) @(posedge core_clk);
        chk("trk_unt", 32'h0, 32'(trk));
        rchk(CTL, 8'hEF, "flag_unl");
        vh = 200;
        wait_lock(1'h1);
        rchk(CTL, 8'hEF, "flag_relock");
    endtask
    task automatic t_manual();
        logic [7:0] d;
        wr(BWC, 8'h00);
        rd(CTL, d);
        rchk(BWC, 8'h00, "bwc_man");
        chk("irq_man", 32'h0, 32'(irq));
        chk("acq_man", 32'h0, 32'(trk));
        wr(CTL, 8'h80);
        wr(CTL, 8'hA0);
        repeat (T_WAIT) @(posedge core_clk);
        wr(BWC, 8'h20);
        rchk(BWC, 8'h20, "trk_man");
        chk("trk_pin", 32'h1, 32'(trk));
        repeat (T_WAIT) @(posedge core_clk);
        wr(CTL, 8'hB0);
        rchk(CTL, 8'hBF, "src_man");
        wr(CTL, 8'hA0);
    endtask
    task automatic t_osc();
        wr(CTL, 8'h80);
        wr(CTL, 8'h90);
        rchk(CTL, 8'h8F, "src_off");
        @(posedge core_clk);
        osc_en <= 1'h0;
        measure(200);
        chk("x_stop", 32'h0, 32'(nx));
        chk("loop_stop", 32'h0, 32'(loop_en));
        chk("osc_out", 32'h0, 32'(opin));
        @(posedge core_clk);
        osc_en <= 1'h1;
        measure(200);
        near("x_run", 10, nx);
    endtask
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            error_cnt++;
            summarize();
        end
    end
    initial
    begin
        repeat (3) @(posedge core_clk);
        nrst <= 1'h1;
        t_regs();
        t_auto();
        t_switch();
        t_unlock();
        t_manual();
        t_osc();
        summarize();
    end
endmodule
`default_nettype wire
